// file: otpa_pkg.sv
package otpa_pkg;
    localparam int          ADDR_W        = 13;
    localparam int          MEM_BYTES     = 8192;         // User program space
    localparam logic [12:0] ADDR_LAST     = 13'h1FFF;     // Address 8191
    localparam logic [12:0] FUSE_ADDR     = 13'h1FCF;     // Address 8143
    localparam logic [12:0] CFG_BYTES     = 13'h0030;     // Lowest 48 bytes
    localparam logic [4:0]  CFG_WORDS     = 5'h10;        // Sixteen words
    localparam logic [7:0]  CFG_RAM_BASE  = 8'h30;        // RAM location 48
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
    localparam logic [7:0]  BYTE_ONES     = 8'hFF;
    localparam logic        PROTECT_RST   = 1'b1;         // Blocked at reset

    // Host command codes; values are local, the serial front end maps them
    typedef enum logic [2:0] {
        OTPA_CMD_NONE   = 3'h0,
        OTPA_CMD_PGM_ON = 3'h1,
        OTPA_CMD_PGM_OFF= 3'h2,
        OTPA_CMD_WRITE  = 3'h3,
        OTPA_CMD_READ   = 3'h4
    } otpa_cmd_t;

    // Boot sequence states, Gray coded along the path
    typedef enum logic [2:0] {
        OTPA_ST_SEL   = 3'b000,
        OTPA_ST_SELW  = 3'b001,
        OTPA_ST_CFG   = 3'b011,
        OTPA_ST_CFGW  = 3'b010,
        OTPA_ST_RUN   = 3'b110
    } otpa_state_t;
endpackage : otpa_pkg

// file: otpa_mem_if.sv
`timescale 1ns/1ps
interface otpa_mem_if;
    import otpa_pkg::*;
    logic              re;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic [7:0]        rdata;
    logic              wrote_before;

    modport ctrl (output re, output we, output addr, output wdata,
                  input rdata, input wrote_before);
    modport mem  (input re, input we, input addr, input wdata,
                  output rdata, output wrote_before);
endinterface : otpa_mem_if

// file: otpa_otp_mem.sv
`timescale 1ns/1ps
// One-time-programmable byte array; an unwritten byte reads as zero
module otpa_otp_mem
    import otpa_pkg::*;
#(
    parameter int DEPTH = MEM_BYTES
) (
    input wire logic clk,
    input wire logic rst,
    otpa_mem_if.mem  port
);
    logic [7:0]     mem_q [DEPTH];
    // Blank at manufacture; reset must never erase a programmed byte
    logic [DEPTH-1:0] otp_program_enable_q = '0;
    logic [7:0]     rdata_q;
    logic           wb_q;

    // Read register; only the read path is cleared by reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= BYTE_ZERO;
            wb_q    <= 1'b0;
        end else begin
            wb_q <= otp_program_enable_q[port.addr];
            // Blank bytes read as zero rather than stale array content
            if (port.re) begin
                rdata_q <= otp_program_enable_q[port.addr] ? mem_q[port.addr]
                                             : BYTE_ZERO;
            end
        end
    end

    // Array data and programmed flags; only a first write lands
    always_ff @(posedge clk) begin
        if (port.we && !otp_program_enable_q[port.addr]) begin
            otp_program_enable_q[port.addr] <= 1'b1;
            mem_q[port.addr]  <= port.wdata;
        end
    end

    assign port.rdata        = rdata_q;
    assign port.wrote_before = wb_q;
endmodule : otpa_otp_mem

// file: otpa_top.sv
`timescale 1ns/1ps
module otpa_top
    import otpa_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    // Host command port, from the serial front end on this clock
    input  wire logic              cmd_valid,
    input  otpa_pkg::otpa_cmd_t    cmd_code,
    input  wire logic [12:0]       cmd_addr,
    input  wire logic [7:0]        cmd_wdata,
    output logic                   cmd_ready,
    output logic                   rsp_valid,
    output logic [7:0]             rsp_data,
    // External EEPROM byte read port
    output logic                   ee_req,
    output logic [12:0]            ee_addr,
    input  wire logic              ee_ack,
    input  wire logic [7:0]        ee_rdata,
    // CPU program fetch port
    input  wire logic              fetch_req,
    input  wire logic [12:0]       fetch_addr,
    output logic                   fetch_valid,
    output logic [7:0]             fetch_data,
    // Configuration word copy into RAM
    output logic                   cfg_we,
    output logic [7:0]             cfg_ram_addr,
    output logic [23:0]            cfg_word,
    // Status
    output logic                   otp_program_enable,
    output logic                   otp_read_protected,
    output logic                   use_eeprom,
    output logic                   boot_done
);
    import otpa_pkg::*;

    typedef struct packed {
        otpa_state_t  st;
        logic         pgm_en;
        logic         prot;
        logic         use_ee;
        logic         rd_pend;
        logic         rd_fuse;
        logic         rd_host;
        logic         rd_fetch;
        logic [12:0]  baddr;
        logic [1:0]   bidx;
        logic [15:0]  acc;
        logic         cfg_we;
        logic [7:0]   cfg_addr;
        logic [23:0]  cfg_word;
        logic         rsp_v;
        logic [7:0]   rsp;
        logic         f_v;
        logic [7:0]   f_d;
        logic         ee_req;
        logic [12:0]  ee_addr;
    } otpa_state_s_t;

    otpa_state_s_t s_q;
    otpa_state_s_t s_d;
    otpa_mem_if    mif ();

    otpa_otp_mem #(.DEPTH(MEM_BYTES)) u_mem (
        .clk  (clk),
        .rst  (rst),
        .port (mif)
    );

    logic host_go;
    logic boot_busy;
    logic [7:0] cfg_byte;
    // Config byte from whichever store boot selected
    assign cfg_byte  = s_q.use_ee ? ee_rdata : mif.rdata;
    assign boot_busy = (s_q.st != OTPA_ST_RUN);
    // Host waits out boot and any read in flight
    assign cmd_ready = !boot_busy && !s_q.rd_pend;
    assign host_go   = cmd_valid && cmd_ready;

    // Memory port steering: boot reads, host commands, CPU fetch
    always_comb begin
        mif.re    = 1'b0;
        mif.we    = 1'b0;
        mif.addr  = cmd_addr;
        mif.wdata = cmd_wdata;
        if (s_q.st == OTPA_ST_CFG && !s_q.use_ee) begin
            mif.re   = 1'b1;
            mif.addr = s_q.baddr;
        end else if (host_go && cmd_code == OTPA_CMD_READ) begin
            mif.re = 1'b1;
        end else if (host_go && cmd_code == OTPA_CMD_WRITE) begin
            mif.we = s_q.pgm_en;
        end else if (!boot_busy && fetch_req && !s_q.use_ee) begin
            mif.re   = 1'b1;
            mif.addr = fetch_addr;
        end
    end

    // Next state of the whole block
    always_comb begin
        s_d          = s_q;
        s_d.cfg_we   = 1'b0;
        s_d.rsp_v    = 1'b0;
        s_d.f_v      = 1'b0;
        s_d.ee_req   = 1'b0;
        case (s_q.st)
            OTPA_ST_SEL: begin
                s_d.ee_req  = 1'b1;
                s_d.ee_addr = 13'h0000;
                s_d.st      = OTPA_ST_SELW;
            end
            OTPA_ST_SELW: begin
                s_d.ee_req = !ee_ack;
                if (ee_ack) begin
                    // Blank or absent EEPROM leaves the OTP in charge
                    s_d.use_ee = (ee_rdata != BYTE_ZERO) &&
                                 (ee_rdata != BYTE_ONES);
                    s_d.baddr  = 13'h0000;
                    s_d.bidx   = 2'd0;
                    s_d.st     = OTPA_ST_CFG;
                end
            end
            OTPA_ST_CFG: begin
                // Config comes in raw even while reads are protected
                if (s_q.use_ee) begin
                    s_d.ee_req  = 1'b1;
                    s_d.ee_addr = s_q.baddr;
                end
                s_d.st = OTPA_ST_CFGW;
            end
            OTPA_ST_CFGW: begin
                if (!s_q.use_ee || ee_ack) begin
                    if (s_q.bidx == 2'd2) begin
                        s_d.cfg_we   = 1'b1;
                        s_d.cfg_word = {s_q.acc, cfg_byte};
                        s_d.cfg_addr = CFG_RAM_BASE +
                                       8'(s_q.baddr / 13'd3);
                        s_d.bidx     = 2'd0;
                    end else begin
                        s_d.acc  = {s_q.acc[7:0], cfg_byte};
                        s_d.bidx = s_q.bidx + 2'd1;
                    end
                    s_d.baddr = s_q.baddr + 13'd1;
                    s_d.st    = (s_q.baddr == CFG_BYTES - 13'd1)
                              ? OTPA_ST_RUN : OTPA_ST_CFG;
                end else begin
                    s_d.ee_req = 1'b1;
                end
            end
            OTPA_ST_RUN: begin
                if (host_go) begin
                    case (cmd_code)
                        OTPA_CMD_PGM_ON:  s_d.pgm_en = 1'b1;
                        OTPA_CMD_PGM_OFF: s_d.pgm_en = 1'b0;
                        // Write lands through the port steering only
                        OTPA_CMD_WRITE:   ;
                        OTPA_CMD_READ: begin
                            s_d.rd_pend  = 1'b1;
                            s_d.rd_host  = 1'b1;
                            s_d.rd_fuse  = (cmd_addr == FUSE_ADDR);
                        end
                        default: ;
                    endcase
                end else if (fetch_req && !s_q.rd_pend && s_q.use_ee) begin
                    s_d.ee_req  = 1'b1;
                    s_d.ee_addr = fetch_addr;
                    s_d.rd_pend = 1'b1;
                end else if (fetch_req && !s_q.rd_pend) begin
                    s_d.rd_pend  = 1'b1;
                    s_d.rd_fetch = 1'b1;
                end
                if (s_q.rd_pend && s_q.rd_host) begin
                    s_d.rd_pend = 1'b0;
                    s_d.rd_host = 1'b0;
                    s_d.rsp_v   = 1'b1;
                    if (s_q.rd_fuse) begin
                        // Fuse check decides protection on a read of the fuse byte only
                        s_d.prot = (mif.rdata != BYTE_ZERO);
                    end
                    // Protected array hides contents from the host
                    s_d.rsp = (s_q.prot && !s_q.rd_fuse) ? BYTE_ZERO
                                                         : mif.rdata;
                end else if (s_q.rd_pend && s_q.rd_fetch) begin
                    s_d.rd_pend  = 1'b0;
                    s_d.rd_fetch = 1'b0;
                    s_d.f_v      = 1'b1;
                    s_d.f_d      = mif.rdata;
                end else if (s_q.rd_pend && s_q.use_ee) begin
                    s_d.ee_req = !ee_ack;
                    if (ee_ack) begin
                        s_d.rd_pend = 1'b0;
                        s_d.f_v     = 1'b1;
                        s_d.f_d     = ee_rdata;
                    end
                end
            end
            default: s_d.st = OTPA_ST_SEL;
        endcase
    end

    // Protection comes up set so no host read leaks before the fuse check
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q      <= '0;
            s_q.st   <= OTPA_ST_SEL;
            s_q.prot <= PROTECT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign rsp_valid          = s_q.rsp_v;
    assign rsp_data           = s_q.rsp;
    assign ee_req             = s_q.ee_req;
    assign ee_addr            = s_q.ee_addr;
    assign fetch_valid        = s_q.f_v;
    assign fetch_data         = s_q.f_d;
    assign cfg_we             = s_q.cfg_we;
    assign cfg_ram_addr       = s_q.cfg_addr;
    assign cfg_word           = s_q.cfg_word;
    assign otp_program_enable = s_q.pgm_en;
    assign otp_read_protected = s_q.prot;
    assign use_eeprom         = s_q.use_ee;
    assign boot_done          = !boot_busy;
endmodule : otpa_top

// file: otpa_ee_model.sv
`timescale 1ns/1ps
// External program EEPROM; answers after a set wait, byte 0 selectable
module otpa_ee_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ee_req,
    input  wire logic [12:0] ee_addr,
    input  wire logic [7:0]  first_byte,
    input  wire logic [3:0]  wait_cycles,
    output logic             ee_ack,
    output logic [7:0]       ee_rdata
);
    logic [3:0] cnt_q;
    // Released data shows the inverse, so a stale byte never looks fresh
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q    <= 4'h0;
            ee_ack   <= 1'b0;
            ee_rdata <= 8'h00;
        end else if (ee_ack) begin
            ee_ack   <= 1'b0;
            ee_rdata <= ~ee_rdata;
        end else if (ee_req && cnt_q >= wait_cycles) begin
            ee_ack   <= 1'b1;
            ee_rdata <= (ee_addr == 13'h0000) ? first_byte
                                              : ee_addr[7:0] ^ 8'hA5;
            cnt_q    <= 4'h0;
        end else if (ee_req) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule : otpa_ee_model

// file: otpa_top_chk.sv
`timescale 1ns/1ps
// Host port, boot reads and status levels of the OTP access block
module otpa_top_chk
    import otpa_pkg::*;
(
    input wire logic           clk,
    input wire logic           rst,
    input wire logic           cmd_valid,
    input otpa_pkg::otpa_cmd_t cmd_code,
    input wire logic [12:0]    cmd_addr,
    input wire logic           cmd_ready,
    input wire logic           rsp_valid,
    input wire logic [7:0]     rsp_data,
    input wire logic           ee_req,
    input wire logic [12:0]    ee_addr,
    input wire logic           cfg_we,
    input wire logic [7:0]     cfg_ram_addr,
    input wire logic           otp_program_enable,
    input wire logic           otp_read_protected,
    input wire logic           boot_done
);
    logic tk;
    logic rd;
    // Taken command, and taken read
    assign tk = cmd_valid && cmd_ready;
    assign rd = tk && cmd_code == OTPA_CMD_READ;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_reset_blocked: assert property (
        $fell(rst) |-> otp_read_protected && !boot_done)
        else $error("reads not blocked after reset");
    a_select_read: assert property (
        $fell(rst) |=> ee_req && ee_addr == 13'h0000)
        else $error("no select read of byte 0");
    a_no_early_cmd: assert property (
        !boot_done |-> !cmd_ready)
        else $error("command accepted during boot");
    a_read_answer: assert property (rd |-> ##2 rsp_valid)
        else $error("read answer late");
    a_cfg_target: assert property (
        cfg_we |-> cfg_ram_addr >= CFG_RAM_BASE && cfg_ram_addr <= 8'h3F)
        else $error("config word outside 48..63");
    a_pgm_on: assert property (
        tk && cmd_code == OTPA_CMD_PGM_ON |=> otp_program_enable)
        else $error("program enable not raised");
    a_pgm_off: assert property (
        tk && cmd_code == OTPA_CMD_PGM_OFF |=> !otp_program_enable)
        else $error("program enable not dropped");
    a_fuse_sets: assert property (
        rd && cmd_addr == FUSE_ADDR ##2 rsp_valid
        |=> otp_read_protected == ($past(rsp_data) != 8'h00))
        else $error("fuse read left wrong protection");
    a_hidden_code: assert property (
        rd && cmd_addr != FUSE_ADDR && otp_read_protected
        |-> ##2 rsp_data == 8'h00)
        else $error("protected byte returned");
endmodule : otpa_top_chk
bind otpa_top otpa_top_chk u_chk (.clk, .rst, .cmd_valid, .cmd_code,
    .cmd_addr, .cmd_ready, .rsp_valid, .rsp_data, .ee_req, .ee_addr,
    .cfg_we, .cfg_ram_addr, .otp_program_enable, .otp_read_protected,
    .boot_done);

// file: otpa_top_bench.sv
`timescale 1ns/1ps
module otpa_top_bench;
    import otpa_pkg::*;
    logic        clk, rst, cmd_valid, fetch_req, cmd_ready, rsp_valid;
    logic        ee_req, ee_ack, fetch_valid, cfg_we, otp_program_enable;
    logic        otp_read_protected, use_eeprom, boot_done;
    otpa_cmd_t   cmd_code;
    logic [12:0] cmd_addr, fetch_addr, ee_addr;
    logic [7:0]  cmd_wdata, rsp_data, ee_rdata, fetch_data, ee_first;
    logic [7:0]  cfg_ram_addr;
    logic [23:0] cfg_word;
    logic [3:0]  ee_wait;
    logic [23:0] otp_cfg [16];
    int          err_count, checks;
    int          cyc = 0;
    otpa_top u_dut (.clk, .rst, .cmd_valid, .cmd_code, .cmd_addr,
        .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_data, .ee_req, .ee_addr,
        .ee_ack, .ee_rdata, .fetch_req, .fetch_addr, .fetch_valid,
        .fetch_data, .cfg_we, .cfg_ram_addr, .cfg_word, .otp_program_enable,
        .otp_read_protected, .use_eeprom, .boot_done);
    otpa_ee_model u_ee (.clk, .rst, .ee_req, .ee_addr, .first_byte(ee_first),
        .wait_cycles(ee_wait), .ee_ack, .ee_rdata);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Cuts a hang short well past the longest boot
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            $display("[ERR] %0t timeout", $time);
            conclude;
        end
    end
    task tick; @(posedge clk); #1; endtask : tick
    task chk_val(input logic [23:0] got, input logic [23:0] exp,
                 input string m);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk_val
    task chk_bit(input logic got, input logic exp, input string m);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %b", $time, m, got);
        end
    endtask : chk_bit
    function automatic logic [7:0] eb(input int a);
        return (a == 0) ? ee_first : 8'(a) ^ 8'hA5;
    endfunction : eb
    // Reset, then judge select and every config word until boot ends
    task boot(input logic [7:0] fb, input logic [3:0] w, input logic ee);
        int n;
        int words;
        words = 0;
        ee_first = fb;
        ee_wait = w;
        rst = 1'b1;
        repeat (16) tick;
        chk_bit(otp_read_protected, 1'b1, "blocked in reset");
        rst = 1'b0;
        for (int i = 0; i < 3000 && boot_done !== 1'b1; i++) begin
            tick;
            if (cfg_we === 1'b1) begin
                n = int'(cfg_ram_addr) - 48;
                words++;
                chk_val(cfg_word, ee ? {eb(3*n), eb(3*n+1), eb(3*n+2)}
                        : otp_cfg[n[3:0]], "cfg word");
            end
        end
        chk_val(24'(words), 24'h00_0010, "cfg count");
        chk_bit(use_eeprom, ee, "store select");
        chk_bit(otp_read_protected, 1'b1, "blocked after boot");
    endtask : boot
    // Holds the request until the edge at which ready is high
    task cmd(input otpa_cmd_t c, input logic [12:0] a, input logic [7:0] d);
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_addr = a;
        cmd_wdata = d;
        for (int i = 0; i < 50 && cmd_ready !== 1'b1; i++) tick;
        tick;
        cmd_valid = 1'b0;
        tick;
    endtask : cmd
    task rd(input logic [12:0] a, input logic [7:0] exp);
        cmd(OTPA_CMD_READ, a, 8'h00);
        chk_bit(rsp_valid, 1'b1, "read answer");
        chk_val(24'(rsp_data), 24'(exp), "read data");
    endtask : rd
    task fe(input logic [12:0] a, input logic [7:0] exp);
        fetch_req = 1'b1;
        fetch_addr = a;
        for (int i = 0; i < 60 && fetch_valid !== 1'b1; i++) tick;
        chk_bit(fetch_valid, 1'b1, "fetch answer");
        chk_val(24'(fetch_data), 24'(exp), "fetch data");
        fetch_req = 1'b0;
        tick;
    endtask : fe
    task t_deprotect;
        rd(FUSE_ADDR, 8'h00);
        chk_bit(otp_read_protected, 1'b0, "unprotect");
        rd(ADDR_LAST, 8'h00);
    endtask : t_deprotect
    // Write refused with enable off, second write to a byte ignored
    task t_program;
        cmd(OTPA_CMD_WRITE, 13'h0064, 8'hA5);
        rd(13'h0064, 8'h00);
        cmd(OTPA_CMD_PGM_ON, 13'h0000, 8'h00);
        chk_bit(otp_program_enable, 1'b1, "enable on");
        cmd(OTPA_CMD_WRITE, 13'h0064, 8'hA5);
        cmd(OTPA_CMD_WRITE, 13'h0064, 8'h3C);
        cmd(OTPA_CMD_WRITE, ADDR_LAST, 8'h81);
        cmd(OTPA_CMD_WRITE, 13'h0003, 8'h12);
        cmd(OTPA_CMD_PGM_OFF, 13'h0000, 8'h00);
        chk_bit(otp_program_enable, 1'b0, "enable off");
        rd(13'h0064, 8'hA5);
        rd(ADDR_LAST, 8'h81);
        fe(13'h0064, 8'hA5);
        otp_cfg[1] = 24'h12_0000;
    endtask : t_program
    task t_protect;
        cmd(OTPA_CMD_PGM_ON, 13'h0000, 8'h00);
        cmd(OTPA_CMD_WRITE, FUSE_ADDR, 8'h77);
        cmd(OTPA_CMD_PGM_OFF, 13'h0000, 8'h00);
        rd(FUSE_ADDR, 8'h77);
        chk_bit(otp_read_protected, 1'b1, "protect");
        rd(13'h0064, 8'h00);
        fe(13'h0064, 8'hA5);
    endtask : t_protect
    // Second select value for the OTP, then a slow EEPROM as store
    task t_alt_boot;
        boot(8'hFF, 4'h0, 1'b0);
        boot(8'h5A, 4'h3, 1'b1);
        fe(13'h0010, eb(16));
    endtask : t_alt_boot
    task conclude;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    initial begin
        rst = 1'b1;
        {cmd_valid, fetch_req, cmd_addr, fetch_addr, cmd_wdata} = '0;
        cmd_code = OTPA_CMD_NONE;
        {ee_first, ee_wait, err_count, checks} = '0;
        foreach (otp_cfg[i]) otp_cfg[i] = 24'h00_0000;
        boot(8'h00, 4'h0, 1'b0);
        t_deprotect;
        t_program;
        t_protect;
        t_alt_boot;
        conclude;
    end
endmodule : otpa_top_bench
